// [inc/sci_ctrl_pkg.sv]
package sci_ctrl_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] OFF_ENABLES_IRQ = 4'h0;
  localparam logic [3:0] OFF_NINTH_DMA   = 4'h4;
  localparam logic [3:0] OFF_MODULE_CFG  = 4'h8;
  localparam logic [3:0] OFF_TX_STATUS   = 4'hc;

  // ----------------------------------------
  // serial_ctrl_enables_irq fields
  // ----------------------------------------
  localparam int B_TX_EMPTY_IRQ_EN = 7;
  localparam int B_DONE_IRQ_EN     = 6;
  localparam int B_RX_FULL_IRQ_EN  = 5;
  localparam int B_IDLE_IRQ_EN     = 4;
  localparam int B_TRANSMIT_ON     = 3;
  localparam int B_RX_ON           = 2;
  localparam int B_RX_STANDBY      = 1;
  localparam int B_BREAK_SEND      = 0;

  // ----------------------------------------
  // serial_ctrl_ninth_bit_dma_err fields
  // ----------------------------------------
  localparam int B_RX_NINTH_BIT    = 7;
  localparam int B_TX_NINTH_BIT    = 6;
  localparam int B_RX_DMA_SEL      = 5;
  localparam int B_TX_DMA_SEL      = 4;
  localparam int B_OVERRUN_IRQ_EN  = 3;
  localparam int B_NOISE_IRQ_EN    = 2;
  localparam int B_FRAMING_IRQ_EN  = 1;
  localparam int B_PARITY_IRQ_EN   = 0;

  // ----------------------------------------
  // module config fields
  // ----------------------------------------
  localparam int B_MODULE_ON = 0;
  localparam int B_CHAR9     = 1;
  localparam int B_WAKE_ADDR = 2;

  // ----------------------------------------
  // Reset values and character lengths
  // ----------------------------------------
  localparam logic [7:0] RST_ENABLES_IRQ = 8'h00;
  localparam logic [5:0] RST_DMA_ERR     = 6'h00;
  localparam logic [2:0] RST_MODULE_CFG  = 3'h0;
  localparam logic [3:0] LEN8_LAST       = 4'h9;
  localparam logic [3:0] LEN9_LAST       = 4'ha;

  // ----------------------------------------
  // Transmit sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_PRE  = 5'h02,
    TX_BRK  = 5'h04,
    TX_DATA = 5'h08,
    TX_ONE  = 5'h10
  } tx_state_t;

  typedef struct packed {
    logic tx_empty;
    logic tx_done;
    logic rx_full;
    logic idle;
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } flags_t;

  typedef struct packed {
    logic tx_irq;
    logic tx_dma;
    logic rx_irq;
    logic rx_dma;
    logic err_irq;
  } requests_t;

endpackage : sci_ctrl_pkg

// [rtl/sci_ctrl.sv]
// Contract
// [RULE1] Tx empty with irq enable and no tx DMA raises tx CPU interrupt.
// [RULE2] Tx empty with irq enable and tx DMA raises tx DMA request.
// [RULE3] Rx full with irq enable and no rx DMA raises rx CPU interrupt.
// [RULE4] Rx full with irq enable and rx DMA raises rx DMA request.
// [RULE5] Tx done raises tx interrupt only with its enable set.
// [RULE6] Idle line raises rx interrupt only with its enable set.
// [RULE7] Rx DMA select blocks all rx CPU interrupts, idle enable included.
// [RULE8] Enabling transmitter first sends 10 or 11 ones preamble.
// [RULE9] Disabling transmitter finishes current character, then line idles high.
// [RULE10] Off-then-on during a character queues one idle character after it.
// [RULE11] Transmit and receive enable writes ignored while module off.
// [RULE12] Receiver disable stops receiver, leaves its flags alone.
// [RULE13] Standby blocks rx interrupts; wake condition clears standby.
// [RULE14] Break set then cleared sends one break then one high bit.
// [RULE15] Break held set sends breaks back to back, no high bits.
// [RULE16] Software should not toggle break right after tx empty sets.
// [RULE17] Received ninth bit captured with data; 8-bit mode copies bit 7.
// [RULE18] Tx ninth bit enters shifter together with the data byte.
// [RULE19] Each error flag interrupts only with its own enable.
// [RULE20] Reset clears enables, selects, standby, break; keeps ninth bits.
// [RULE21] Module on enables baud; off forces tx flags, blocks tx interrupts.
// [RULE22] Wake select picks address mark or idle line wake.
// [RULE23] Gated error conditions merge into one error interrupt line.
// [RULE24] DMA request stays while its flag is set.
`timescale 1ns/1ps
module sci_ctrl (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire sci_ctrl_pkg::flags_t flags,
  input  wire logic                 tx_tick,
  input  wire logic [7:0]           data_buffer,
  output logic                      tx_take,
  output logic                      tx_busy,
  output logic                      serial_out_pin,
  input  wire logic                 rx_char_valid,
  input  wire logic [8:0]           rx_char,
  input  wire logic                 rx_idle_seen,
  output logic                      rx_on,
  output logic                      baud_on,
  output logic                      force_tx_flags,
  output sci_ctrl_pkg::requests_t   requests
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]              en;
    logic [5:0]              dma_err;
    logic [2:0]              cfg;
    sci_ctrl_pkg::tx_state_t tx;
    logic [3:0]              cnt;
    logic [10:0]             sh;
    logic                    pend_pre;
    logic                    out;
    logic                    take;
    logic                    ack;
    logic [7:0]              rdat;
  } state_t;

  state_t st;
  state_t next_st;
  logic   tx_ninth_bit;
  logic   rx_ninth_bit;
  logic   next_tx_ninth_bit;
  logic   next_rx_ninth_bit;

  logic   module_on;
  logic   char9;
  logic   wr;
  logic   rd_cycle;
  logic   char_end;
  logic   transmit_on;
  logic   rx_standby;
  logic   break_send;
  logic   wake;
  logic   rx_msb;
  logic [3:0] last_bit;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;
  logic   bus_req;
  logic   tx_idle;
  logic   tx_in_one;
  logic   at_last;

  logic   tx_empty_irq_en;
  logic   done_irq_en;
  logic   rx_full_irq_en;
  logic   idle_irq_en;
  logic   tx_dma_sel;
  logic   rx_dma_sel;
  logic   overrun_irq_en;
  logic   noise_irq_en;
  logic   framing_irq_en;
  logic   parity_irq_en;
  logic   wake_addr;

  logic   tx_empty_term;
  logic   done_term;
  logic   rx_full_term;
  logic   idle_term;
  logic   overrun_term;
  logic   noise_term;
  logic   framing_term;
  logic   parity_term;
  logic   rx_irq_blocked;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // A source only counts when its own enable is set
  function automatic logic gate(input logic enable, input logic source);
    return enable && source;
  endfunction : gate

  // Last bit index, shared by preamble, break and data frames
  function automatic logic [3:0] frame_last(input logic nine);
    return nine ? sci_ctrl_pkg::LEN9_LAST : sci_ctrl_pkg::LEN8_LAST;
  endfunction : frame_last

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Counter and shifter hold an eleven-bit frame at most
  if (sci_ctrl_pkg::LEN9_LAST > 4'ha) begin : g_len_fits
    $error("nine-bit frame does not fit the shifter");
  end
  if (sci_ctrl_pkg::LEN8_LAST >= sci_ctrl_pkg::LEN9_LAST) begin : g_len_order
    $error("eight-bit frame must be shorter than nine-bit frame");
  end
  // Configuration fields must sit inside the three stored bits
  if (sci_ctrl_pkg::B_WAKE_ADDR > 2 || sci_ctrl_pkg::B_CHAR9 > 2) begin : g_cfg_fits
    $error("configuration field outside stored bits");
  end

  assign module_on   = st.cfg[sci_ctrl_pkg::B_MODULE_ON];
  assign char9       = st.cfg[sci_ctrl_pkg::B_CHAR9];
  assign transmit_on = st.en[sci_ctrl_pkg::B_TRANSMIT_ON];
  assign rx_standby  = st.en[sci_ctrl_pkg::B_RX_STANDBY];
  assign break_send  = st.en[sci_ctrl_pkg::B_BREAK_SEND];
  assign last_bit    = frame_last(char9);
  assign wbyte       = wb_dat_i[7:0];

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  assign tx_empty_irq_en = st.en[sci_ctrl_pkg::B_TX_EMPTY_IRQ_EN];
  assign done_irq_en     = st.en[sci_ctrl_pkg::B_DONE_IRQ_EN];
  assign rx_full_irq_en  = st.en[sci_ctrl_pkg::B_RX_FULL_IRQ_EN];
  assign idle_irq_en     = st.en[sci_ctrl_pkg::B_IDLE_IRQ_EN];
  assign tx_dma_sel      = st.dma_err[sci_ctrl_pkg::B_TX_DMA_SEL];
  assign rx_dma_sel      = st.dma_err[sci_ctrl_pkg::B_RX_DMA_SEL];
  assign overrun_irq_en  = st.dma_err[sci_ctrl_pkg::B_OVERRUN_IRQ_EN];
  assign noise_irq_en    = st.dma_err[sci_ctrl_pkg::B_NOISE_IRQ_EN];
  assign framing_irq_en  = st.dma_err[sci_ctrl_pkg::B_FRAMING_IRQ_EN];
  assign parity_irq_en   = st.dma_err[sci_ctrl_pkg::B_PARITY_IRQ_EN];
  assign wake_addr       = st.cfg[sci_ctrl_pkg::B_WAKE_ADDR];

  // Write commits on the edge where the master sees ack
  assign bus_req  = wb_cyc_i && wb_stb_i;
  assign rd_cycle = bus_req && !st.ack;
  assign wr       = bus_req && wb_we_i && st.ack && wb_sel_i[0];

  // ----------------------------------------
  // Wake detection
  // ----------------------------------------
  assign rx_msb = char9 ? rx_char[8] : rx_char[7];
  assign wake   = wake_addr
                  ? (rx_char_valid && rx_msb)  // RULE22
                  : rx_idle_seen;              // RULE22

  // ----------------------------------------
  // Serial side
  // ----------------------------------------
  // Idle and the single high bit last one tick, so each ends at once
  assign tx_idle   = st.tx == sci_ctrl_pkg::TX_IDLE;
  assign tx_in_one = st.tx == sci_ctrl_pkg::TX_ONE;
  assign at_last   = st.cnt == last_bit;
  assign char_end  = tx_idle || at_last || tx_in_one;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    unique case (wb_adr_i)
      sci_ctrl_pkg::OFF_ENABLES_IRQ: rd_mux = st.en;
      sci_ctrl_pkg::OFF_NINTH_DMA:   rd_mux = {rx_ninth_bit, tx_ninth_bit, st.dma_err};
      sci_ctrl_pkg::OFF_MODULE_CFG:  rd_mux = {5'h00, st.cfg};
      sci_ctrl_pkg::OFF_TX_STATUS:   rd_mux = {2'h0, st.pend_pre, st.tx};
      default:                       rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st           = st;
    next_tx_ninth_bit = tx_ninth_bit;
    next_rx_ninth_bit = rx_ninth_bit;
    next_st.take      = 1'b0;
    next_st.ack       = rd_cycle;
    if (rd_cycle) begin
      next_st.rdat = rd_mux;
    end

    // Hardware wake clears standby; a software write below wins
    if (rx_standby && wake) begin
      next_st.en[sci_ctrl_pkg::B_RX_STANDBY] = 1'b0;  // RULE13
    end

    if (rx_char_valid) begin
      next_rx_ninth_bit = rx_msb;  // RULE17
    end

    if (wr) begin
      unique case (wb_adr_i)
        sci_ctrl_pkg::OFF_ENABLES_IRQ: begin
          next_st.en = wbyte;
          if (!module_on) begin
            next_st.en[sci_ctrl_pkg::B_TRANSMIT_ON] = transmit_on;  // RULE11
            next_st.en[sci_ctrl_pkg::B_RX_ON]       = st.en[sci_ctrl_pkg::B_RX_ON];  // RULE11
          end else if (wbyte[sci_ctrl_pkg::B_TRANSMIT_ON] && !transmit_on) begin
            // Rising enable queues a preamble, or an idle char mid-frame
            next_st.pend_pre = 1'b1;  // RULE8 RULE10
          end
        end
        sci_ctrl_pkg::OFF_NINTH_DMA: begin
          next_tx_ninth_bit = wbyte[sci_ctrl_pkg::B_TX_NINTH_BIT];
          next_st.dma_err   = wbyte[5:0];
        end
        sci_ctrl_pkg::OFF_MODULE_CFG: begin
          next_st.cfg = wbyte[2:0];
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // Transmit sequencer, one step per bit tick
    // ----------------------------------------
    if (tx_tick) begin
      if (!char_end) begin
        next_st.cnt = st.cnt + 4'h1;
        unique case (st.tx)
          sci_ctrl_pkg::TX_DATA: begin
            next_st.out = st.sh[1];
            next_st.sh  = {1'b1, st.sh[10:1]};
          end
          sci_ctrl_pkg::TX_BRK:  next_st.out = 1'b0;
          default:               next_st.out = 1'b1;
        endcase
      end else begin
        next_st.cnt = 4'h0;
        if (transmit_on && break_send) begin
          // Break preempts a pending preamble
          next_st.tx       = sci_ctrl_pkg::TX_BRK;  // RULE15 RULE16
          next_st.out      = 1'b0;
          next_st.pend_pre = 1'b0;
        end else if (st.tx == sci_ctrl_pkg::TX_BRK) begin
          next_st.tx  = sci_ctrl_pkg::TX_ONE;  // RULE14
          next_st.out = 1'b1;
        end else if (!transmit_on) begin
          next_st.tx  = sci_ctrl_pkg::TX_IDLE;  // RULE9
          next_st.out = 1'b1;
        end else if (st.pend_pre) begin
          next_st.tx       = sci_ctrl_pkg::TX_PRE;  // RULE8 RULE10
          next_st.out      = 1'b1;
          next_st.pend_pre = 1'b0;
        end else if (!flags.tx_empty) begin
          next_st.tx   = sci_ctrl_pkg::TX_DATA;
          next_st.out  = 1'b0;
          next_st.take = 1'b1;
          next_st.sh   = {1'b1, (char9 ? tx_ninth_bit : 1'b1), data_buffer, 1'b0};  // RULE18
        end else begin
          next_st.tx  = sci_ctrl_pkg::TX_IDLE;
          next_st.out = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st          <= '0;
      st.en       <= sci_ctrl_pkg::RST_ENABLES_IRQ;  // RULE20
      st.dma_err  <= sci_ctrl_pkg::RST_DMA_ERR;      // RULE20
      st.cfg      <= sci_ctrl_pkg::RST_MODULE_CFG;
      st.tx       <= sci_ctrl_pkg::TX_IDLE;
      st.out      <= 1'b1;
      st.sh       <= '1;
    end else begin
      st <= next_st;
    end
  end

  // Ninth bits survive reset, so they sit outside the reset domain
  always_ff @(posedge clk_sys) begin
    tx_ninth_bit <= next_tx_ninth_bit;  // RULE20
    rx_ninth_bit <= next_rx_ninth_bit;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_ack_o       = st.ack;
  assign wb_dat_o       = {24'h000000, st.rdat};
  assign serial_out_pin = st.out;
  assign tx_take        = st.take;
  assign tx_busy        = !tx_idle || st.pend_pre;
  // Receiver stops, flags are owned elsewhere and untouched
  assign rx_on          = st.en[sci_ctrl_pkg::B_RX_ON];  // RULE12
  assign baud_on        = module_on;   // RULE21
  assign force_tx_flags = !module_on;  // RULE21


  // ----------------------------------------
  // Request routing
  // ----------------------------------------
  // The DMA selects steer the data flags away from the CPU path
  assign tx_empty_term = gate(tx_empty_irq_en && !tx_dma_sel, flags.tx_empty);  // RULE1
  assign done_term     = gate(done_irq_en, flags.tx_done);  // RULE5
  assign rx_full_term  = gate(rx_full_irq_en, flags.rx_full);  // RULE3
  assign idle_term     = gate(idle_irq_en, flags.idle);  // RULE6
  assign overrun_term  = gate(overrun_irq_en, flags.overrun);  // RULE19
  assign noise_term    = gate(noise_irq_en, flags.noise);  // RULE19
  assign framing_term  = gate(framing_irq_en, flags.framing);  // RULE19
  assign parity_term   = gate(parity_irq_en, flags.parity);  // RULE19
  // Standby silences only the rx CPU path; DMA, tx and errors keep flowing
  assign rx_irq_blocked = rx_dma_sel || rx_standby;  // RULE7 RULE13

  always_comb begin
    requests.tx_irq  = module_on  // RULE21
                       && (tx_empty_term || done_term);
    requests.tx_dma  = tx_empty_irq_en && tx_dma_sel  // RULE2
                       && flags.tx_empty;  // RULE24
    requests.rx_irq  = !rx_irq_blocked
                       && (rx_full_term || idle_term);
    requests.rx_dma  = rx_full_irq_en && rx_dma_sel  // RULE4
                       && flags.rx_full;  // RULE24
    requests.err_irq = overrun_term  // RULE23
                       || noise_term
                       || framing_term
                       || parity_term;
  end

endmodule : sci_ctrl

// [sim/sci_ctrl_monitor.sv]
`timescale 1ns/1ps
module sci_ctrl_monitor (
  input wire logic                    clk_sys,
  input wire logic                    rstn,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [3:0]              wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic                    wb_ack_o,
  input wire sci_ctrl_pkg::flags_t    flags,
  input wire logic                    tx_tick,
  input wire logic                    tx_busy,
  input wire logic                    serial_out_pin,
  input wire logic                    rx_on,
  input wire logic                    baud_on,
  input wire logic                    force_tx_flags,
  input wire sci_ctrl_pkg::requests_t requests
);
  // ----------
  // Shadow enables
  // ----------
  logic [7:0] en;
  logic [5:0] sl;
  logic       wr;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      en <= 8'h00;
      sl <= 6'h00;
    end else if (wr && wb_adr_i == sci_ctrl_pkg::OFF_ENABLES_IRQ) begin
      en <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i == sci_ctrl_pkg::OFF_NINTH_DMA) begin
      sl <= wb_dat_i[5:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_once: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
  a_tx_irq_map:
    assert property (requests.tx_irq == (baud_on && (flags.tx_empty && en[7] && !sl[4]
      || flags.tx_done && en[6]))) else $error("tx irq wrong");
  a_tx_dma_map:
    assert property (baud_on |-> requests.tx_dma == (flags.tx_empty && en[7] && sl[4]))
      else $error("tx dma wrong");
  a_rx_dma_map:
    assert property (requests.rx_dma == (flags.rx_full && en[5] && sl[5]))
      else $error("rx dma wrong");
  a_rx_irq_gate:
    assert property (requests.rx_irq |-> !sl[5] && (flags.rx_full && en[5] || flags.idle && en[4]))
      else $error("rx irq wrong");
  a_err_irq_map:
    assert property (requests.err_irq == |(flags[3:0] & sl[3:0])) else $error("err irq wrong");
  a_force_inv: assert property (force_tx_flags != baud_on) else $error("force flags wrong");
  a_rx_on_gate: assert property ($rose(rx_on) |-> $past(baud_on)) else $error("rx on gated");
  a_out_on_tick: assert property ($changed(serial_out_pin) |-> $past(tx_tick))
    else $error("out moved off tick");
  a_idle_high: assert property (!tx_busy |-> serial_out_pin) else $error("idle not high");
endmodule : sci_ctrl_monitor

// [sim/sci_far_end.sv]
`timescale 1ns/1ps
module sci_far_end (
  input wire logic clk_sys,
  input wire logic tx_tick,
  input wire logic serial_out_pin,
  input wire logic char9
);
  // ----------
  // Remote receiver, one sample per bit
  // ----------
  int   fq[$];
  int   preq[$];
  int   ones = 0;
  int   n = 0;
  int   acc = 0;
  logic tick_q = 1'b0;
  // Sampled a cycle after the tick, once the new bit has landed
  always @(posedge clk_sys) begin
    tick_q <= tx_tick;
    if (tick_q) begin
      if (n == 0 && serial_out_pin) begin
        ones = ones + 1;
      end else begin
        acc = acc | (int'(serial_out_pin) << n);
        n = n + 1;
        if (n == (char9 ? 11 : 10)) begin
          fq.push_back(acc);
          preq.push_back(ones);
          ones = 0;
          n = 0;
          acc = 0;
        end
      end
    end
  end
endmodule : sci_far_end

// [sim/sci_ctrl_tb.sv]
`timescale 1ns/1ps
module sci_ctrl_tb;
  // ----------
  // Design and far end
  // ----------
  logic                    clk_sys = 1'b0;
  logic                    rstn = 1'b0;
  logic                    wb_cyc_i = 1'b0;
  logic                    wb_stb_i = 1'b0;
  logic                    wb_we_i = 1'b0;
  logic [3:0]              wb_adr_i = 4'h0;
  logic [3:0]              wb_sel_i = 4'h1;
  logic [31:0]             wb_dat_i = 32'h0;
  logic [31:0]             wb_dat_o;
  logic                    wb_ack_o;
  sci_ctrl_pkg::flags_t    flags = 8'h80;
  logic                    tx_tick = 1'b0;
  logic [7:0]              data_buffer = 8'h00;
  logic                    rx_char_valid = 1'b0;
  logic [8:0]              rx_char = 9'h000;
  logic                    rx_idle_seen = 1'b0;
  logic                    tx_take, tx_busy, serial_out_pin, rx_on, baud_on, force_tx_flags;
  sci_ctrl_pkg::requests_t requests;
  logic                    char9 = 1'b0;
  logic [2:0]              tdiv = 3'h0;
  logic [31:0]             q;
  logic [3:0]              al [5] = '{4'h0, 4'h4, 4'h8, 4'h2, 4'hc};
  logic [7:0]              am [5] = '{8'hff, 8'h3f, 8'h07, 8'hff, 8'h3f};
  logic [7:0]              ar [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  int                      mismatches = 0;
  int                      cmp_count = 0;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tdiv <= tdiv + 3'h1;
    tx_tick <= tdiv == 3'h7;
  end
  sci_ctrl sci_ctrl_i (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .flags, .tx_tick, .data_buffer, .tx_take, .tx_busy,
    .serial_out_pin, .rx_char_valid, .rx_char, .rx_idle_seen, .rx_on, .baud_on,
    .force_tx_flags, .requests);
  sci_far_end sci_far_end_i (.clk_sys, .tx_tick, .serial_out_pin, .char9);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1 && ++k < 50);
    q = wb_dat_o;
    if (k >= 50) mismatches++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (sci_far_end_i.fq.size() < n && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    check("frame count", sci_far_end_i.fq.size(), n);
  endtask : wait_frames
  // Model of the request routing
  function automatic logic [4:0] exp_req(input logic [7:0] e, input logic [5:0] s,
                                         input logic [7:0] f);
    logic [4:0] r;
    r[4] = f[7] & e[7] & ~s[4] | f[6] & e[6];
    r[3] = f[7] & e[7] & s[4];
    r[2] = ~e[1] & ~s[5] & (f[5] & e[5] | f[4] & e[4]);
    r[1] = f[5] & e[5] & s[5];
    r[0] = |(f[3:0] & s[3:0]);
    return r;
  endfunction : exp_req
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #100us;
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [7:0] d, e;
    logic [5:0] s;
    logic [8:0] r;
    logic       t;
    int         k;
    void'($urandom(32'h7537fe99));
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, al[i], 8'h00);
      check("reset reg", q & {24'h0, am[i]}, {24'h0, ar[i]});
    end
    wb(1'b1, 4'h0, 8'h0c);
    wb(1'b0, 4'h0, 8'h00);
    check("gated enables", q, 32'h0);
    check("rx_on", rx_on, 1'b0);
    $display("test reset and gating done");
    wb(1'b1, 4'h8, 8'h01);
    for (int i = 0; i < 24; i++) begin
      e = 8'($urandom) & 8'hf2;
      s = 6'($urandom);
      wb(1'b1, 4'h0, e);
      wb(1'b1, 4'h4, {2'b00, s});
      flags <= 8'($urandom);
      @(posedge clk_sys);
      check("requests", requests, exp_req(e, s, flags));
      wb(1'b0, 4'h0, 8'h00);
      check("enables", q, e);
    end
    wb(1'b1, 4'h0, 8'h00);
    wb(1'b1, 4'h4, 8'h00);
    flags <= 8'h80;
    $display("test routing done");
    for (int c = 0; c < 2; c++) begin
      d = 8'($urandom);
      t = 1'($urandom);
      char9 <= c[0];
      wb(1'b1, 4'h8, {6'h0, c[0], 1'b1});
      wb(1'b1, 4'h4, {1'b0, t, 6'h0});
      data_buffer <= d;
      flags <= 8'h00;
      @(posedge clk_sys iff tx_tick);
      wb(1'b1, 4'h0, 8'h0c);
      sci_far_end_i.fq.delete();
      sci_far_end_i.preq.delete();
      sci_far_end_i.ones = 0;
      k = 0;
      while (tx_take !== 1'b1 && k < 4000) begin
        @(posedge clk_sys);
        k++;
      end
      flags <= 8'h80;
      // Off in mid character: the frame still has to finish
      wb(1'b1, 4'h0, 8'h04);
      wait_frames(1);
      check("preamble", sci_far_end_i.preq[0], 10 + c);
      check("frame", sci_far_end_i.fq[0], (int'(d) << 1) | (c ? (int'(t) << 9) | 1024 : 512));
      r = 9'($urandom);
      rx_char <= r;
      rx_char_valid <= 1'b1;
      @(posedge clk_sys);
      rx_char_valid <= 1'b0;
      @(posedge clk_sys);
      wb(1'b0, 4'h4, 8'h00);
      check("rx ninth", q[7], c ? r[8] : r[7]);
      repeat (240) @(posedge clk_sys);
      check("no frame after off", sci_far_end_i.fq.size(), 1);
    end
    $display("test frames done");
    char9 <= 1'b0;
    wb(1'b1, 4'h8, 8'h01);
    wb(1'b1, 4'h0, 8'h08);
    repeat (120) @(posedge clk_sys);
    sci_far_end_i.fq.delete();
    sci_far_end_i.preq.delete();
    wb(1'b1, 4'h0, 8'h09);
    wait_frames(2);
    wb(1'b1, 4'h0, 8'h08);
    repeat (240) @(posedge clk_sys);
    check("break 1", sci_far_end_i.fq[0], 0);
    check("break 2", sci_far_end_i.fq[1], 0);
    check("break gap", sci_far_end_i.preq[1], 0);
    check("high after break", sci_far_end_i.ones > 0, 1);
    $display("test break done");
    report_and_stop();
  end
endmodule : sci_ctrl_tb
bind sci_ctrl sci_ctrl_monitor sci_ctrl_monitor_i (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .flags, .tx_tick, .tx_busy,
  .serial_out_pin, .rx_on, .baud_on, .force_tx_flags, .requests);
